// >>> esc_ctrl.sv
// Controller that drives the asynchronous 256K x 4 SRAM pins
`default_nettype none
module esc_ctrl
  import esc_pkg::*;
#(
  parameter esc_grade_t GRADE = GRADE_FAST
) (
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire esc_pkg::esc_req_t         req,
  input  wire logic                      req_valid,
  output logic                           req_ready,
  output logic     [esc_pkg::DATA_W-1:0] rd_data,
  output logic                           rd_valid,
  output esc_pkg::esc_pins_t             pins,
  input  wire logic [esc_pkg::DATA_W-1:0] read_data_out
);
  // Cycle counts per grade
  localparam logic [3:0] C_AA   = 4'(min_cyc(T_AA_PS[GRADE]));
  localparam logic [3:0] C_OH   = 4'(min_cyc(T_OH_PS));
  localparam logic [3:0] C_SU   = 4'(min_cyc(T_WSA_PS[GRADE]));
  localparam int         C_WI   = min_cyc(T_W_PS[GRADE]) >
                                  min_cyc(T_WSD2_PS[GRADE]) ?
                                  min_cyc(T_W_PS[GRADE]) :
                                  min_cyc(T_WSD2_PS[GRADE]);
  localparam logic [3:0] C_W    = 4'(C_WI);
  localparam logic [3:0] C_HOLD = 4'(min_cyc(T_WH_PS));
  localparam logic [3:0] C_RCS  = 4'(wait_cyc(T_RCS_PS[GRADE]));
  localparam logic [3:0] C_ACS  = 4'(wait_cyc(T_ACS_PS[GRADE]));
  // Data passes two sync flops after the pins settle
  localparam logic [3:0] C_SYNC = 4'h2;

  esc_state_t        state_reg, state_next;
  esc_pins_t         pins_reg, pins_next;
  logic [3:0]        cnt_reg, cnt_next;
  logic              is_rd_reg, is_rd_next;
  logic [DATA_W-1:0] rd_data_reg, rd_data_next;
  logic              rd_valid_reg, rd_valid_next;
  logic [DATA_W-1:0] q_sync;

  // Pin inputs come from another timing domain
  esc_sync #(
    .W (DATA_W)
  ) u_sync (
    .clk (clk),
    .rst (rst),
    .d   (read_data_out),
    .q   (q_sync)
  );

  assign req_ready = (state_reg == ST_IDLE);
  assign pins      = pins_reg;
  assign rd_data   = rd_data_reg;
  assign rd_valid  = rd_valid_reg;

  // Sequencer: one access at a time, select dropped between accesses
  always_comb begin
    state_next    = state_reg;
    pins_next     = pins_reg;
    cnt_next      = cnt_reg;
    is_rd_next    = is_rd_reg;
    rd_data_next  = rd_data_reg;
    rd_valid_next = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        if (req_valid) begin
          pins_next.word_address   = req.addr;
          pins_next.write_data_in  = req.wdata;
          pins_next.select_n       = 1'b0;
          pins_next.write_strobe_n = 1'b1;
          is_rd_next               = ~req.write;
          state_next               = ST_SETUP;
          // Read waits for the slower of address and select access
          if (!req.write) begin
            cnt_next = ((C_AA > C_ACS) ? C_AA : C_ACS) + C_SYNC;
          end else begin
            cnt_next = C_SU;
          end
        end
      end
      ST_SETUP: begin
        if (cnt_reg > CNT_ONE) begin
          cnt_next = cnt_reg - CNT_ONE;
        end else if (is_rd_reg) begin
          // Sample after access time; old data ignored per hold window
          rd_data_next  = q_sync;
          rd_valid_next = 1'b1;
          pins_next.select_n = 1'b1;
          cnt_next      = C_RCS + C_OH;
          state_next    = ST_WAIT;
        end else begin
          pins_next.write_strobe_n = 1'b0;
          cnt_next   = C_W;
          state_next = ST_PULSE;
        end
      end
      ST_PULSE: begin
        if (cnt_reg > CNT_ONE) begin
          cnt_next = cnt_reg - CNT_ONE;
        end else begin
          // Rising edge stores the word
          pins_next.write_strobe_n = 1'b1;
          cnt_next   = C_HOLD;
          state_next = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (cnt_reg > CNT_ONE) begin
          cnt_next = cnt_reg - CNT_ONE;
        end else begin
          // Address, data, select held; now deselect
          pins_next.select_n = 1'b1;
          cnt_next   = C_RCS;
          state_next = ST_WAIT;
        end
      end
      ST_WAIT: begin
        // Outputs settle low before the next access
        if (cnt_reg > CNT_ONE) begin
          cnt_next = cnt_reg - CNT_ONE;
        end else begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // Registers only; pins idle deselected
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg    <= ST_IDLE;
      pins_reg     <= '{word_address: '0, write_data_in: '0,
                        select_n: 1'b1, write_strobe_n: 1'b1};
      cnt_reg      <= '0;
      is_rd_reg    <= 1'b0;
      rd_data_reg  <= '0;
      rd_valid_reg <= 1'b0;
    end else begin
      state_reg    <= state_next;
      pins_reg     <= pins_next;
      cnt_reg      <= cnt_next;
      is_rd_reg    <= is_rd_next;
      rd_data_reg  <= rd_data_next;
      rd_valid_reg <= rd_valid_next;
    end
  end
endmodule
`default_nettype wire

// >>> esc_ctrl_monitor.sv
// Checker for the controller's memory pin sequencing
`default_nettype none
module esc_ctrl_monitor
  import esc_pkg::*;
#(
  parameter esc_grade_t GRADE = GRADE_FAST
) (
  input wire logic                       clk,
  input wire logic                       rst,
  input wire esc_pkg::esc_req_t          req,
  input wire logic                       req_valid,
  input wire logic                       req_ready,
  input wire logic [esc_pkg::DATA_W-1:0] rd_data,
  input wire logic                       rd_valid,
  input wire esc_pkg::esc_pins_t         pins,
  input wire logic [esc_pkg::DATA_W-1:0] read_data_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  AST_IDLE_DESEL:
    assert property (req_ready |-> pins.select_n && pins.write_strobe_n)
    else $error("memory selected while idle");
  AST_STROBE_SEL:
    assert property (!pins.write_strobe_n |-> !pins.select_n)
    else $error("write strobe without select");
  AST_SETUP:
    assert property ($fell(pins.write_strobe_n) |-> !$past(pins.select_n)
      && $stable(pins.word_address)) else $error("address set-up short");
  AST_PULSE:
    assert property ($fell(pins.write_strobe_n) |=> $rose(pins.write_strobe_n))
    else $error("write pulse width wrong");
  AST_DATA:
    assert property (!pins.write_strobe_n |-> $stable(pins.write_data_in))
    else $error("write data moved in pulse");
  AST_HOLD:
    assert property ($rose(pins.write_strobe_n) |-> !pins.select_n
      && $stable(pins.word_address) && $stable(pins.write_data_in)
      ##1 $rose(pins.select_n)) else $error("write hold broken");
  AST_ADDR:
    assert property (!pins.select_n && !$past(pins.select_n)
      |-> $stable(pins.word_address)) else $error("address moved in access");
  AST_READ_LAT:
    assert property (rd_valid |-> $past(pins.select_n, 4)
      && !$past(pins.select_n, 3) && !$past(pins.select_n, 1)
      && pins.write_strobe_n) else $error("read latency wrong");
  AST_RDV:
    assert property (rd_valid |=> !rd_valid) else $error("read pulse long");
  AST_RECOVER:
    assert property ($rose(pins.select_n) |-> !req_ready)
    else $error("no select recovery wait");
endmodule
bind esc_ctrl esc_ctrl_monitor #(.GRADE(GRADE)) u_mon (.clk(clk), .rst(rst),
  .req(req), .req_valid(req_valid), .req_ready(req_ready),
  .rd_data(rd_data), .rd_valid(rd_valid), .pins(pins),
  .read_data_out(read_data_out));
`default_nettype wire

// >>> esc_pkg.sv
// Package for the external SRAM controller: grades, timing, types
// Function
// - Read is select low, strobe high; device shows word at address.
// - Write is a low strobe pulse while selected; stored at rising edge.
// - Address and select stable before strobe falls: 0 ns, 1 ns slow grade.
// - Write strobe held low at least 8/10/10 ns by grade.
// - Write data stable 6/8/8 ns before strobe rises.
// - Data, address and select held 1 ns after strobe rises.
`default_nettype none
package esc_pkg;
  localparam int ADDR_W = 18;
  localparam int DATA_W = 4;
  localparam int CLK_PS = 25000;

  typedef enum logic [1:0] {
    GRADE_FAST = 2'h0,
    GRADE_MID  = 2'h1,
    GRADE_SLOW = 2'h2
  } esc_grade_t;

  // Times in picoseconds, one column per grade where the grades differ
  localparam int T_AA_PS   [3] = '{10000, 12000, 15000};
  localparam int T_ACS_PS  [3] = '{5000, 6000, 7000};
  localparam int T_RCS_PS  [3] = '{5000, 6000, 7000};
  localparam int T_OH_PS       = 2500;
  localparam int T_WSA_PS  [3] = '{0, 0, 1000};
  localparam int T_W_PS    [3] = '{8000, 10000, 10000};
  localparam int T_WSD2_PS [3] = '{6000, 8000, 8000};
  localparam int T_WH_PS       = 1000;
  localparam int T_WS_PS       = 6000;
  localparam int T_WR_PS   [3] = '{12000, 14000, 16000};

  // Least times round up, at least one cycle
  function automatic int min_cyc(input int ps);
    int c;
    c = (ps + CLK_PS - 1) / CLK_PS;
    return (c < 1) ? 1 : c;
  endfunction

  // Longest waits round up too: controller must wait past them
  function automatic int wait_cyc(input int ps);
    return min_cyc(ps);
  endfunction

  localparam logic [3:0] CNT_ONE = 4'h1;

  typedef struct packed {
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } esc_req_t;

  typedef struct packed {
    logic [ADDR_W-1:0] word_address;
    logic [DATA_W-1:0] write_data_in;
    logic              select_n;
    logic              write_strobe_n;
  } esc_pins_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_SETUP = 3'h1,
    ST_PULSE = 3'h3,
    ST_HOLD  = 3'h2,
    ST_WAIT  = 3'h6
  } esc_state_t;
endpackage
`default_nettype wire

// >>> esc_sram_model.sv
// Behavioural model of the asynchronous 256K x 4 memory
`default_nettype none
module esc_sram_model
  import esc_pkg::*;
#(
  parameter int  T_ACC  = 10,
  parameter real T_WMIN = 8.0,
  parameter real T_DSU  = 6.0
) (
  input  wire esc_pkg::esc_pins_t         pins,
  output logic [esc_pkg::DATA_W-1:0]      q,
  output int                              viol
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [DATA_W-1:0] mem [2**ADDR_W];
  logic              we_prev = 1'b1;
  logic [DATA_W-1:0] d_prev  = '0;
  realtime           t_fall  = 0.0;
  realtime           t_data  = 0.0;
  initial q = '0;
  initial viol = 0;
  // Store on strobe rise, then settle outputs after worst delays;
  // controller timing faults are counted so the bench can see them
  always @(pins) begin
    if (pins.write_data_in != d_prev)
      t_data = $realtime;
    d_prev = pins.write_data_in;
    if (!pins.write_strobe_n && we_prev) begin
      t_fall = $realtime;
      if (pins.select_n)
        viol++;
    end
    if (pins.write_strobe_n && !we_prev && !pins.select_n) begin
      if ($realtime - t_fall < T_WMIN)
        viol++;
      if ($realtime - t_data < T_DSU)
        viol++;
      mem[pins.word_address] = pins.write_data_in;
    end
    we_prev = pins.write_strobe_n;
    if (pins.select_n || !pins.write_strobe_n) begin
      q <= #5 '0;
    end else begin
      q <= #2.5 ~q;
      q <= #T_ACC mem[pins.word_address];
    end
  end
endmodule
`default_nettype wire

// >>> esc_sync.sv
// Two-flop synchroniser for the read-data pins
`default_nettype none
module esc_sync #(
  parameter int W = 4
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_reg;

  // First stage read only by second
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// >>> tb_esc_ctrl.sv
// Testbench for the memory controller against the memory model
`default_nettype none
module tb_esc_ctrl;
  timeunit 1ns;
  timeprecision 100ps;
  import esc_pkg::*;
  logic              clk = 0, rst = 1, req_valid = 0, req_ready, rd_valid;
  esc_req_t          req = '0;
  esc_pins_t         pins;
  logic [DATA_W-1:0] rd_data, q, r;
  int                error_cnt = 0, checks = 0, cyc = 0, viol;
  esc_ctrl #(.GRADE(GRADE_FAST)) uut (.clk(clk), .rst(rst), .req(req),
    .req_valid(req_valid), .req_ready(req_ready), .rd_data(rd_data),
    .rd_valid(rd_valid), .pins(pins), .read_data_out(q));
  esc_sram_model mem_i (.pins(pins), .q(q), .viol(viol));
  initial forever #12.5 clk = ~clk;
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      results();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One request, held until taken; reads wait for the data pulse
  task automatic xfer(input logic w, input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] d);
    int n;
    n = 0;
    @(posedge clk);
    #1 req = '{write: w, addr: a, wdata: d};
    req_valid = 1;
    // Ready looked at off the edge; the next edge takes the request
    while (req_ready !== 1'b1 && n < 20) begin
      @(posedge clk);
      #1 n++;
    end
    @(posedge clk);
    #1 req_valid = 0;
    chk({7'h0, req_ready}, 8'h0);
    n = 1;
    while (!w && rd_valid !== 1'b1 && n < 20) begin
      @(posedge clk);
      #1 n++;
    end
    if (!w) chk(n[7:0], 8'h4);
    r = rd_data;
  endtask
  task automatic test_reset;
    chk({4'h0, req_ready, rd_valid, pins.select_n, pins.write_strobe_n},
        8'hB);
    $display("test_reset done");
  endtask
  // Corner addresses written back to back, then read back
  task automatic test_corners;
    logic [ADDR_W-1:0] a [4] = '{18'h00000, 18'h3FFFF, 18'h15555, 18'h2AAAA};
    for (int i = 0; i < 4; i++) xfer(1, a[i], 4'(i + 5));
    for (int i = 0; i < 4; i++) begin
      xfer(0, a[i], 4'h0);
      chk({4'h0, r}, 8'(i + 5));
    end
    $display("test_corners done");
  endtask
  // Every data value overwrites one word and reads straight back
  task automatic test_values;
    for (int v = 0; v < 16; v++) begin
      xfer(1, 18'h00123, 4'(v));
      xfer(0, 18'h00123, 4'h0);
      chk({4'h0, r}, 8'(v));
    end
    chk(8'(viol), 8'h0);
    $display("test_values done");
  endtask
  task automatic results;
    $display("checks=%0d error_cnt=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    #1 rst = 0;
    test_reset();
    test_corners();
    test_values();
    results();
  end
endmodule
`default_nettype wire
